/* lsc_pkg.sv */
package lsc_pkg;

  // Command codes of the register bank
  localparam logic [7:0]  CMD_IOUT_LEVEL = 8'h49;
  localparam logic [7:0]  CMD_GAIN_LIMIT = 8'h4b;
  localparam logic [7:0]  CMD_DAC_INIT   = 8'h4c;
  localparam logic [7:0]  CMD_MAKER_ID   = 8'h50;
  localparam logic [7:0]  CMD_PART_ID    = 8'h51;
  localparam logic [7:0]  CMD_APP_ID     = 8'h52;
  localparam logic [7:0]  CMD_APP_VER    = 8'h53;
  localparam logic [7:0]  CMD_SS_BOUNDS  = 8'h5a;

  // Field positions
  localparam int          EXIT_MSB   = 15;
  localparam int          EXIT_LSB   = 8;
  localparam int          ENTER_MSB  = 7;
  localparam int          ENTER_LSB  = 0;
  localparam int          FACTOR_MSB = 15;
  localparam int          FACTOR_LSB = 8;
  localparam int          LIMIT_MSB  = 7;
  localparam int          LIMIT_LSB  = 0;
  localparam int          START_MSB  = 4;
  localparam int          START_LSB  = 0;
  localparam int          VLVL_MSB   = 15;
  localparam int          VLVL_LSB   = 10;
  localparam int          UPPER_MSB  = 9;
  localparam int          UPPER_LSB  = 4;
  localparam int          LOWER_MSB  = 3;
  localparam int          LOWER_LSB  = 0;

  // Reset values
  localparam logic [15:0] RST_IOUT_LEVEL = 16'h0000;
  localparam logic [15:0] RST_GAIN_LIMIT = 16'h0000;
  localparam logic [7:0]  RST_DAC_INIT   = 8'h00;
  localparam logic [15:0] RST_APP_ID     = 16'h0000;
  localparam logic [15:0] RST_APP_VER    = 16'h0000;
  localparam logic [15:0] RST_SS_BOUNDS  = 16'h0000;

  // Loop arithmetic
  localparam int          START_SHIFT = 3;
  localparam int          LOOP_FRAC   = 8;
  localparam int          ACC_W       = 24;

  // Serial framing
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT   = 4'h7;
  localparam logic [1:0]  LEN_BYTE      = 2'h1;
  localparam logic [1:0]  LEN_WORD      = 2'h2;
  localparam logic [7:0]  READ_FILL     = 8'hff;

  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_CMD      = 9'h008,
    ST_CMD_ACK  = 9'h010,
    ST_WDATA    = 9'h020,
    ST_WACK     = 9'h040,
    ST_RDATA    = 9'h080,
    ST_RACK     = 9'h100
  } lsc_state_t;

endpackage : lsc_pkg

/* lsc_sync.sv */
`timescale 1ns/1ps
module lsc_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic [1:0] sync_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_reg <= {2{INIT}};
    else
      sync_reg <= {sync_reg[0], d};
  end

  assign q = sync_reg[1];
endmodule : lsc_sync

/* lsc_top.sv */
`timescale 1ns/1ps
module lsc_top
  import lsc_pkg::*;
#(
  parameter logic [6:0]  BUS_ADDR   = 7'h20,
  parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h5678, // Arbitrary value
  parameter int          QUAL_W     = 6,
  parameter int          DLY_W      = 4
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic [15:0]       measured_iout,
  input  wire logic              iout_sample_tick,
  input  wire logic [QUAL_W-1:0] skip_qual_rounds,
  input  wire logic              bypass_allow,
  output logic                   skip_enable,
  input  wire logic              loop_start,
  input  wire logic              loop_enable,
  input  wire logic              loop_tick,
  input  wire logic signed [7:0] loop_error,
  output logic [7:0]             output_comp_dac_value,
  input  wire logic              softstart_active,
  input  wire logic [7:0]        measured_vout,
  input  wire logic [5:0]        ton_measured,
  input  wire logic              low_stage_disable_bit,
  input  wire logic [DLY_W-1:0]  mid_stage_sr_delay,
  input  wire logic [DLY_W-1:0]  short_stage_sr_delay,
  output logic                   short_ton_stage,
  output logic                   mid_ton_stage,
  output logic [DLY_W:0]         rectifier_delay_code
);
  typedef struct packed {
    lsc_state_t              st;
    logic                    scl_d;
    logic                    sda_d;
    logic [3:0]              bit_cnt;
    logic [7:0]              shift;
    logic                    is_read;
    logic                    master_nack;
    logic [7:0]              cmd;
    logic [1:0]              wr_cnt;
    logic [15:0]             wr_buf;
    logic [1:0]              rd_idx;
    logic                    sda_oe;
    logic [15:0]             iout_level;
    logic [15:0]             gain_limit;
    logic [7:0]              dac_init;
    logic [15:0]             maker_id;
    logic [15:0]             part_id;
    logic [15:0]             app_id;
    logic [15:0]             app_ver;
    logic [15:0]             ss_bounds;
    logic [QUAL_W-1:0]       qual_cnt;
    logic                    skip_en;
    logic signed [ACC_W-1:0] acc;
    logic [7:0]              dac;
    logic                    short_stage;
    logic                    mid_stage;
    logic [DLY_W:0]          dly_code;
  } lsc_regs_t;
  lsc_regs_t state_reg;
  lsc_regs_t state_next;
  logic rst_sync_n;
  logic scl_s;
  logic sda_s;
  lsc_sync #(.INIT(1'b0)) u_rst_sync (
    .clk(sys_clk), .rst_n(rst_n), .d(1'b1), .q(rst_sync_n));
  lsc_sync #(.INIT(1'b1)) u_scl_sync (
    .clk(sys_clk), .rst_n(rst_n), .d(scl_i), .q(scl_s));
  lsc_sync #(.INIT(1'b1)) u_sda_sync (
    .clk(sys_clk), .rst_n(rst_n), .d(sda_i), .q(sda_s));
  // Transfer length of each command, zero when unmapped
  function automatic logic [1:0] cmd_len(input logic [7:0] c);
    unique case (c)
      CMD_DAC_INIT:   cmd_len = LEN_BYTE;
      CMD_IOUT_LEVEL, CMD_GAIN_LIMIT, CMD_MAKER_ID, CMD_PART_ID,
      CMD_APP_ID, CMD_APP_VER, CMD_SS_BOUNDS: cmd_len = LEN_WORD;
      default:        cmd_len = 2'h0;
    endcase
  endfunction : cmd_len
  function automatic logic [15:0] rd_word(input lsc_regs_t s);
    unique case (s.cmd)
      CMD_IOUT_LEVEL: rd_word = s.iout_level;
      CMD_GAIN_LIMIT: rd_word = s.gain_limit;
      CMD_DAC_INIT:   rd_word = {READ_FILL, s.dac_init};
      CMD_MAKER_ID:   rd_word = s.maker_id;
      CMD_PART_ID:    rd_word = s.part_id;
      CMD_APP_ID:     rd_word = s.app_id;
      CMD_APP_VER:    rd_word = s.app_ver;
      CMD_SS_BOUNDS:  rd_word = s.ss_bounds;
      default:        rd_word = {READ_FILL, READ_FILL};
    endcase
  endfunction : rd_word
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    bus_start;
  logic                    bus_stop;
  logic [15:0]             rd_data;
  logic [7:0]              rd_byte;
  logic [14:0]             iout_half;
  logic [7:0]              vout_half;
  logic signed [16:0]      loop_term;
  logic signed [ACC_W-1:0] acc_upd;
  logic signed [ACC_W-1:0] start_x8;
  logic signed [ACC_W-1:0] dac_raw;
  logic signed [ACC_W-1:0] dac_lim;
  logic signed [ACC_W-1:0] start_lim;
  logic                    stages_ok;
  assign scl_rise  = scl_s & ~state_reg.scl_d;
  assign scl_fall  = ~scl_s & state_reg.scl_d;
  assign bus_start = scl_s & state_reg.scl_d & ~sda_s & state_reg.sda_d;
  assign bus_stop  = scl_s & state_reg.scl_d & sda_s & ~state_reg.sda_d;
  assign rd_data   = rd_word(state_reg);
  assign rd_byte   = (state_reg.rd_idx == 2'h0) ? rd_data[7:0] :
                     (state_reg.rd_idx == 2'h1 && cmd_len(state_reg.cmd) == LEN_WORD) ?
                     rd_data[15:8] : READ_FILL;
  assign iout_half = measured_iout[15:1];
  assign vout_half = {1'b0, measured_vout[7:1]};
  assign loop_term = $signed({1'b0, state_reg.gain_limit[FACTOR_MSB:FACTOR_LSB]})
                     * loop_error;
  assign acc_upd   = state_reg.acc + ACC_W'(loop_term);
  assign start_x8  = ACC_W'({state_reg.dac_init[START_MSB:START_LSB], 3'b000});
  assign dac_raw   = start_x8 - (acc_upd >>> LOOP_FRAC);
  assign dac_lim   = ACC_W'({1'b0, state_reg.gain_limit[LIMIT_MSB:LIMIT_LSB]});
  assign start_lim = (start_x8 > dac_lim) ? dac_lim : start_x8;
  assign stages_ok = ~(low_stage_disable_bit &&
                       vout_half > {2'b00, state_reg.ss_bounds[VLVL_MSB:VLVL_LSB]});
  always_comb
  begin
    state_next       = state_reg;
    state_next.scl_d = scl_s;
    state_next.sda_d = sda_s;
    if (bus_start)
    begin
      state_next.st      = ST_ADDR;
      state_next.bit_cnt = 4'h0;
      state_next.sda_oe  = 1'b0;
    end
    else if (bus_stop)
    begin
      if (state_reg.st == ST_WDATA && state_reg.wr_cnt == cmd_len(state_reg.cmd))
      begin
        unique case (state_reg.cmd)
          CMD_IOUT_LEVEL: state_next.iout_level = state_reg.wr_buf;
          CMD_GAIN_LIMIT: state_next.gain_limit = state_reg.wr_buf;
          CMD_DAC_INIT:   state_next.dac_init   = state_reg.wr_buf[7:0];
          CMD_MAKER_ID:   state_next.maker_id   = state_reg.wr_buf;
          CMD_PART_ID:    state_next.part_id    = state_reg.wr_buf;
          CMD_APP_ID:     state_next.app_id     = state_reg.wr_buf;
          CMD_APP_VER:    state_next.app_ver    = state_reg.wr_buf;
          CMD_SS_BOUNDS:  state_next.ss_bounds  = state_reg.wr_buf;
          default:        state_next.cmd        = state_reg.cmd;
        endcase
      end
      state_next.st     = ST_IDLE;
      state_next.sda_oe = 1'b0;
    end
    else
    begin
      unique case (state_reg.st)
        ST_IDLE: state_next.sda_oe = 1'b0;
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (scl_rise)
          begin
            state_next.shift   = {state_reg.shift[6:0], sda_s};
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          end
          else if (scl_fall && state_reg.bit_cnt == BITS_PER_BYTE)
          begin
            state_next.bit_cnt = 4'h0;
            state_next.st      = ST_IDLE;
            if (state_reg.st == ST_ADDR && state_reg.shift[7:1] == BUS_ADDR)
            begin
              state_next.is_read = state_reg.shift[0];
              state_next.rd_idx  = 2'h0;
              state_next.sda_oe  = 1'b1;
              state_next.st      = ST_ADDR_ACK;
            end
            else if (state_reg.st == ST_CMD && cmd_len(state_reg.shift) != 2'h0)
            begin
              state_next.cmd    = state_reg.shift;
              state_next.wr_cnt = 2'h0;
              state_next.sda_oe = 1'b1;
              state_next.st     = ST_CMD_ACK;
            end
            else if (state_reg.st == ST_WDATA && state_reg.wr_cnt < cmd_len(state_reg.cmd))
            begin
              if (state_reg.wr_cnt == 2'h0)
                state_next.wr_buf[7:0] = state_reg.shift;
              else
                state_next.wr_buf[15:8] = state_reg.shift;
              state_next.wr_cnt = state_reg.wr_cnt + 2'h1;
              state_next.sda_oe = 1'b1;
              state_next.st     = ST_WACK;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            state_next.bit_cnt = 4'h0;
            if (state_reg.is_read)
            begin
              state_next.shift  = rd_byte;
              state_next.sda_oe = ~rd_byte[7];
              state_next.st     = ST_RDATA;
            end
            else
            begin
              state_next.sda_oe = 1'b0;
              state_next.st     = ST_CMD;
            end
          end
        end
        ST_CMD_ACK, ST_WACK:
        begin
          if (scl_fall)
          begin
            state_next.sda_oe = 1'b0;
            state_next.st     = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            state_next.shift   = {state_reg.shift[6:0], 1'b0};
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
            state_next.sda_oe  = ~state_reg.shift[6];
            if (state_reg.bit_cnt == LAST_TX_BIT)
            begin
              state_next.sda_oe = 1'b0;
              state_next.rd_idx = state_reg.rd_idx + 2'h1;
              state_next.st     = ST_RACK;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
            state_next.master_nack = sda_s;
          else if (scl_fall)
          begin
            state_next.bit_cnt = 4'h0;
            if (state_reg.master_nack)
              state_next.st = ST_IDLE;
            else
            begin
              state_next.shift  = rd_byte;
              state_next.sda_oe = ~rd_byte[7];
              state_next.st     = ST_RDATA;
            end
          end
        end
        default:
        begin
          state_next.st     = ST_IDLE;
          state_next.sda_oe = 1'b0;
        end
      endcase
    end
    // Light-load bypass control
    if (!bypass_allow ||
        iout_half > {7'h00, state_reg.iout_level[EXIT_MSB:EXIT_LSB]})
    begin
      state_next.skip_en  = 1'b0;
      state_next.qual_cnt = '0;
    end
    else if (iout_half <= {7'h00, state_reg.iout_level[ENTER_MSB:ENTER_LSB]})
    begin
      if (iout_sample_tick && state_reg.qual_cnt < skip_qual_rounds)
        state_next.qual_cnt = state_reg.qual_cnt + QUAL_W'(1);
      if (state_reg.qual_cnt >= skip_qual_rounds)
        state_next.skip_en = 1'b1;
    end
    else
      state_next.qual_cnt = '0;
    // Output compensation trim loop
    if (loop_start)
    begin
      state_next.acc = '0;
      state_next.dac = start_lim[7:0];
    end
    else if (loop_enable && loop_tick)
    begin
      state_next.acc = acc_upd;
      if (dac_raw < 0)
        state_next.dac = 8'h00;
      else if (dac_raw > dac_lim)
        state_next.dac = dac_lim[7:0];
      else
        state_next.dac = dac_raw[7:0];
    end
    else
      state_next.dac = state_reg.dac;
    // Soft-start rectifier turn-off staging
    state_next.short_stage = 1'b0;
    state_next.mid_stage   = 1'b0;
    state_next.dly_code    = '0;
    if (softstart_active && stages_ok)
    begin
      if (ton_measured < {2'b00, state_reg.ss_bounds[LOWER_MSB:LOWER_LSB]})
      begin
        state_next.short_stage = 1'b1;
        state_next.dly_code    = {1'b0, short_stage_sr_delay} + (DLY_W+1)'(1);
      end
      else if (ton_measured < state_reg.ss_bounds[UPPER_MSB:UPPER_LSB])
      begin
        state_next.mid_stage = 1'b1;
        state_next.dly_code  = {1'b0, mid_stage_sr_delay} + (DLY_W+1)'(1);
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_reg             <= '0;
      state_reg.st          <= ST_IDLE;
      state_reg.scl_d       <= 1'b1;
      state_reg.sda_d       <= 1'b1;
      state_reg.iout_level  <= RST_IOUT_LEVEL;
      state_reg.gain_limit  <= RST_GAIN_LIMIT;
      state_reg.dac_init    <= RST_DAC_INIT;
      state_reg.maker_id    <= MAKER_CODE;
      state_reg.part_id     <= PART_CODE;
      state_reg.app_id      <= RST_APP_ID;
      state_reg.app_ver     <= RST_APP_VER;
      state_reg.ss_bounds   <= RST_SS_BOUNDS;
    end
    else
      state_reg <= state_next;
  end
  assign sda_o                 = 1'b0;
  assign sda_oe                = state_reg.sda_oe;
  assign skip_enable           = state_reg.skip_en;
  assign output_comp_dac_value = state_reg.dac;
  assign short_ton_stage       = state_reg.short_stage;
  assign mid_ton_stage         = state_reg.mid_stage;
  assign rectifier_delay_code  = state_reg.dly_code;
endmodule : lsc_top

/* lsc_properties.sv */
`timescale 1ns/1ps
module lsc_properties
  import lsc_pkg::*;
#(
  parameter int QUAL_W = 6,
  parameter int DLY_W  = 4
) (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             bypass_allow,
  input wire logic             skip_enable,
  input wire logic             loop_start,
  input wire logic             loop_enable,
  input wire logic             loop_tick,
  input wire logic [7:0]       output_comp_dac_value,
  input wire logic             softstart_active,
  input wire logic [7:0]       measured_vout,
  input wire logic             low_stage_disable_bit,
  input wire logic [DLY_W-1:0] mid_stage_sr_delay,
  input wire logic [DLY_W-1:0] short_stage_sr_delay,
  input wire logic             short_ton_stage,
  input wire logic             mid_ton_stage,
  input wire logic [DLY_W:0]   rectifier_delay_code
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  skip_barred_a: assert property (!bypass_allow |=> !skip_enable)
    else $error("bypass pin high while feature off");
  skip_rise_a: assert property ($rose(skip_enable) |-> $past(bypass_allow))
    else $error("bypass entered without permission");
  dac_hold_a: assert property (!loop_start && !(loop_enable && loop_tick)
    |=> $stable(output_comp_dac_value))
    else $error("dac code moved without cause");
  stage_excl_a: assert property (!(short_ton_stage && mid_ton_stage))
    else $error("both stages active");
  stage_idle_a: assert property (!softstart_active |=> !short_ton_stage && !mid_ton_stage)
    else $error("stage active outside soft start");
  stage_cut_a: assert property (low_stage_disable_bit && measured_vout[7]
    |=> !short_ton_stage && !mid_ton_stage)
    else $error("stage active above voltage limit");
  short_dly_a: assert property (short_ton_stage
    |-> rectifier_delay_code == $past(short_stage_sr_delay) + 1'b1)
    else $error("short stage delay code wrong");
  mid_dly_a: assert property (mid_ton_stage
    |-> rectifier_delay_code == $past(mid_stage_sr_delay) + 1'b1)
    else $error("mid stage delay code wrong");
  no_stage_a: assert property (!short_ton_stage && !mid_ton_stage
    |-> rectifier_delay_code == '0)
    else $error("delay code without stage");
endmodule : lsc_properties

/* lsc_host_model.sv */
`timescale 1ns/1ps
module lsc_host_model
  import lsc_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h20
) (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Half bus period, above the four-cycle minimum
  task automatic hp();
    repeat (6) @(negedge sys_clk);
  endtask : hp

  // Start when s is high, stop when low; data moves clear of the clock edge
  task automatic cond(input logic s);
    repeat (2) @(negedge sys_clk);
    sda_rel = s;
    hp();
    scl = 1'b1;
    hp();
    sda_rel = ~s;
    hp();
    if (s)
      scl = 1'b0;
  endtask : cond

  task automatic bitx(input logic b, output logic r);
    repeat (2) @(negedge sys_clk);
    sda_rel = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda_line;
    scl = 1'b0;
  endtask : bitx

  // One byte, high bit first, then the acknowledge slot
  task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r[i]);
    bitx(a, ak);
  endtask : xfer

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n, output logic nak);
    logic [7:0] r;
    logic       a;
    cond(1'b1);
    xfer({ADDR, 1'b0}, 1'b1, r, nak);
    xfer(cmd, 1'b1, r, a);
    nak |= a;
    for (int i = 0; i < n; i++)
    begin
      xfer(d[8*i +: 8], 1'b1, r, a);
      nak |= a;
    end
    cond(1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d, output logic nak);
    logic [7:0] r;
    logic       a;
    d = 16'h0000;
    cond(1'b1);
    xfer({ADDR, 1'b0}, 1'b1, r, nak);
    xfer(cmd, 1'b1, r, a);
    nak |= a;
    cond(1'b1);
    xfer({ADDR, 1'b1}, 1'b1, r, a);
    nak |= a;
    for (int i = 0; i < n; i++)
    begin
      xfer(8'hff, i == n - 1, r, a);
      d[8*i +: 8] = r;
    end
    cond(1'b0);
  endtask : rd
endmodule : lsc_host_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import lsc_pkg::*;
  localparam logic [15:0] MK = 16'h0a5c; // Arbitrary value
  localparam logic [15:0] PT = 16'h3c71; // Arbitrary value
  logic              sys_clk, rst_n, scl, sda_rel, sda_o, sda_oe, sda_line, nak;
  logic              tick, allow, skip, l_start, l_en, l_tick, ss, dis, short_s, mid_s;
  logic [15:0]       iout, rv, obs, d;
  logic [7:0]        dac, vout;
  logic [7:0]        cmds [8];
  logic signed [7:0] err;
  logic [5:0]        ton, qual;
  logic [3:0]        mid_d, short_d;
  logic [4:0]        code;
  logic [15:0]       exp_q [$];
  int                n_fail, num_checks, acc, e;
  event              obs_ev;

  assign sda_line = sda_rel & ~(sda_oe & ~sda_o);

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  lsc_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

  lsc_top #(.MAKER_CODE(MK), .PART_CODE(PT)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .measured_iout(iout), .iout_sample_tick(tick), .skip_qual_rounds(qual),
    .bypass_allow(allow), .skip_enable(skip), .loop_start(l_start), .loop_enable(l_en),
    .loop_tick(l_tick), .loop_error(err), .output_comp_dac_value(dac), .softstart_active(ss),
    .measured_vout(vout), .ton_measured(ton), .low_stage_disable_bit(dis),
    .mid_stage_sr_delay(mid_d), .short_stage_sr_delay(short_d), .short_ton_stage(short_s),
    .mid_ton_stage(mid_s), .rectifier_delay_code(code));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask : pulse

  // Note the expectation, then hand the observed value to the watcher
  task automatic see(input logic [15:0] want, input logic [15:0] seen);
    exp_q.push_back(want);
    obs = seen;
    -> obs_ev;
  endtask : see

  task automatic rchk(input logic [7:0] cmd, input int n, input logic [15:0] want);
    host.rd(cmd, n, rv, nak);
    see(want, rv);
  endtask : rchk

  always @(obs_ev)
    check(obs, exp_q.pop_front());

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    {rst_n, iout, tick, qual, allow, l_start, l_en, l_tick, err} = '0;
    {ss, vout, ton, dis, mid_d, short_d} = '0;
    cmds = '{CMD_IOUT_LEVEL, CMD_GAIN_LIMIT, CMD_DAC_INIT, CMD_MAKER_ID, CMD_PART_ID,
             CMD_APP_ID, CMD_APP_VER, CMD_SS_BOUNDS};
    void'($urandom(32'h06220304));
    cyc(16);
    rst_n = 1'b1;
    cyc(6);
    for (int i = 0; i < 8; i++)
      rchk(cmds[i], (i == 2) ? 1 : 2, (i == 3) ? MK : (i == 4) ? PT : 16'h0000);
    $display("reset values test done");
    for (int i = 0; i < 7; i++)
    begin
      d = (i == 2) ? {8'h00, 8'($urandom)} : 16'($urandom);
      host.wr(cmds[i], d, (i == 2) ? 1 : 2, nak);
      rchk(cmds[i], (i == 2) ? 1 : 2, d);
    end
    host.wr(8'h4a, 16'h5a5a, 2, nak);
    see(16'h0001, {15'h0, nak});
    $display("register access test done");
    host.wr(CMD_IOUT_LEVEL, 16'h4010, 2, nak);
    {qual, allow, iout} = {6'd3, 1'b1, 16'h0020};
    for (int i = 1; i <= 3; i++)
    begin
      pulse(tick);
      see({15'h0, i == 3}, {15'h0, skip});
    end
    iout = 16'h0081;
    cyc(3);
    see(16'h0001, {15'h0, skip});
    iout = 16'h0082;
    cyc(2);
    see(16'h0000, {15'h0, skip});
    $display("bypass test done");
    host.wr(CMD_GAIN_LIMIT, 16'h1060, 2, nak);
    host.wr(CMD_DAC_INIT, 16'h00e5, 1, nak);
    host.wr(CMD_DAC_INIT, 16'h771c, 2, nak);
    see(16'h0001, {15'h0, nak});
    rchk(CMD_DAC_INIT, 1, 16'h00e5);
    rchk(CMD_DAC_INIT, 2, 16'hffe5);
    pulse(l_start);
    see(16'h0028, {8'h00, dac});
    acc = 0;
    e = 40;
    for (int i = 0; i < 16; i++)
    begin
      err = 8'($urandom);
      l_en = ($urandom % 4) != 0;
      pulse(l_tick);
      if (l_en)
      begin
        acc += 16 * err;
        e = 40 - (acc >>> 8);
        e = (e < 0) ? 0 : (e > 96) ? 96 : e;
      end
      see(16'(e), {8'h00, dac});
    end
    host.wr(CMD_DAC_INIT, 16'h001f, 1, nak);
    pulse(l_start);
    see(16'h0060, {8'h00, dac});
    $display("trim loop test done");
    host.wr(CMD_SS_BOUNDS, {6'd20, 6'd30, 4'd10}, 2, nak);
    for (int i = 0; i < 80; i++)
    begin
      {ss, dis, vout, mid_d, short_d} = 18'($urandom);
      ton = 6'(i % 40);
      cyc(2);
      d = 16'h0000;
      if (ss && !(dis && vout[7:1] > 7'd20) && ton < 6'd30)
        d = (ton < 6'd10) ? {9'h000, 2'b10, 5'(short_d + 5'd1)}
                          : {9'h000, 2'b01, 5'(mid_d + 5'd1)};
      see(d, {9'h000, short_s, mid_s, code});
    end
    $display("soft start test done");
    tally_and_finish();
  end
endmodule : tb_top

bind lsc_top lsc_properties #(.QUAL_W(QUAL_W), .DLY_W(DLY_W)) chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .bypass_allow(bypass_allow), .skip_enable(skip_enable),
  .loop_start(loop_start), .loop_enable(loop_enable), .loop_tick(loop_tick),
  .output_comp_dac_value(output_comp_dac_value), .softstart_active(softstart_active),
  .measured_vout(measured_vout), .low_stage_disable_bit(low_stage_disable_bit),
  .mid_stage_sr_delay(mid_stage_sr_delay), .short_stage_sr_delay(short_stage_sr_delay),
  .short_ton_stage(short_ton_stage), .mid_ton_stage(mid_ton_stage),
  .rectifier_delay_code(rectifier_delay_code));
